// ### logic/usdp_pkg.sv
/*
  Shared constants and types of the shadow character port: the alias window,
  the character field and its reset value, the queue depth and the link modes.
  Assumes the bus master uses 32-bit byte addresses, one aligned word per alias.
*/
package usdp_pkg;

    // documented port sits at the second alias; sixteen words start here
    localparam logic [31:0] CHAR_PORT_BASE      = 32'h5000_1130;
    localparam logic [31:0] CHAR_PORT_OWN       = 32'h5000_1134;
    localparam logic [31:0] CHAR_PORT_SPAN      = 32'h0000_0040;
    localparam int          CHAR_PORT_ALIASES   = 16;

    localparam int          CHAR_W              = 8;
    localparam int          PORT_W              = 16;
    localparam logic [7:0]  CHAR_RESET          = 8'h00;
    localparam logic [31:0] RDATA_RESET         = 32'h0000_0000;
    localparam logic [23:0] UPPER_ZERO          = 24'h00_0000;

    localparam int          QUEUE_DEPTH_DEFAULT = 16;

    typedef enum logic [0:0] {
        USDP_UART = 1'b0,
        USDP_IR   = 1'b1
    } usdp_link_e;

endpackage : usdp_pkg

// ### logic/usdp_port.sv
/*
  Shadow character port of a serial controller: receive buffer or receive
  queue on read, transmit holder or transmit queue on write, at sixteen
  aliased words. Assumes the receiver and the transmitter shifters, line
  framing, line status latching and interrupts live outside on clk_sys.
*/
// Our own choice: the plain strobed port.
// Overview of operation
// (R1) same port answers at sixteen word aliases
// (R2) read bits 7:0 give uart or ir character
// (R3) master trusts data only while available flag
// (R4) no queue: new character overwrites, flags overrun
// (R5) queue mode: read returns oldest, then advances
// (R6) full receive queue drops arrival, flags overrun
// (R7) write bits 7:0 go to uart or ir
// (R8) master writes only while holder empty flag set
// (R9) no queue: write clears empty, rewrite replaces
// (R10) queue mode: accept depth characters, drop when full
// (R11) transmit depth is a build-time parameter
// (R12) bits 15:8 read zero, character resets zero
`timescale 1ns/100ps
module usdp_port #(
    // (R11) build-time depth
    parameter int TX_DEPTH = usdp_pkg::QUEUE_DEPTH_DEFAULT
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic [31:0]                    reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [31:0]                         reg_rdata,
    input  wire logic                           fifo_enable,
    input  wire usdp_pkg::usdp_link_e           link_mode,
    input  wire logic                           rx_uart_valid,
    input  wire logic [usdp_pkg::CHAR_W-1:0]    rx_uart_char,
    input  wire logic                           rx_ir_valid,
    input  wire logic [usdp_pkg::CHAR_W-1:0]    rx_ir_char,
    output logic                                tx_uart_valid,
    output logic                                tx_ir_valid,
    output logic [usdp_pkg::CHAR_W-1:0]         tx_char,
    input  wire logic                           tx_char_ready,
    output logic                                rx_char_available_flag,
    output logic                                tx_holder_empty_flag,
    output logic                                rx_overrun_pulse
);
    import usdp_pkg::*;

    typedef struct packed {
        logic [CHAR_W-1:0] rx_hold;
        logic              rx_avail;
        logic [CHAR_W-1:0] tx_hold;
        logic              tx_busy;
        logic [31:0]       rdata;
        logic              overrun;
        logic              fifo_en_d;
    } usdp_state_s;

    usdp_state_s                  r;
    usdp_state_s                  next_r;
    logic [31:0]                  port_off;
    logic                         port_hit;
    logic                         rd_hit;
    logic                         wr_hit;
    logic                         flush;
    logic                         rx_valid;
    logic [CHAR_W-1:0]            rx_char;
    logic                         rxq_push_ready;
    logic                         rxq_valid;
    logic [CHAR_W-1:0]            rxq_data;
    logic                         txq_push_ready;
    logic                         txq_valid;
    logic [CHAR_W-1:0]            txq_data;
    logic [$clog2(TX_DEPTH+1)-1:0] txq_count;
    logic [$clog2(QUEUE_DEPTH_DEFAULT+1)-1:0] rxq_count;
    logic                         tx_valid;

    // (R1) sixteen aliased words
    assign port_off = reg_addr - CHAR_PORT_BASE;
    assign port_hit = (port_off < CHAR_PORT_SPAN) && (reg_addr[1:0] == 2'h0);
    assign rd_hit   = reg_rd && port_hit;
    assign wr_hit   = reg_wr && port_hit;
    // switching queue mode empties both queues and holders
    assign flush    = (fifo_enable != r.fifo_en_d);

    // (R2) receive source by link mode
    assign rx_valid = (link_mode == USDP_IR) ? rx_ir_valid : rx_uart_valid;
    assign rx_char  = (link_mode == USDP_IR) ? rx_ir_char  : rx_uart_char;

    usdp_queue #(
        .DEPTH      (QUEUE_DEPTH_DEFAULT)
    ) u_rx_queue (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .flush      (flush),
        .push_valid (fifo_enable && rx_valid),
        .push_ready (rxq_push_ready),
        .push_data  (rx_char),
        .pop_valid  (rxq_valid),
        .pop_ready  (fifo_enable && rd_hit),
        .pop_data   (rxq_data),
        .count      (rxq_count)
    );

    // (R10) transmit queue drops when full
    usdp_queue #(
        .DEPTH      (TX_DEPTH)
    ) u_tx_queue (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .flush      (flush),
        .push_valid (fifo_enable && wr_hit),
        .push_ready (txq_push_ready),
        .push_data  (reg_wdata[CHAR_W-1:0]),
        .pop_valid  (txq_valid),
        .pop_ready  (fifo_enable && tx_char_ready),
        .pop_data   (txq_data),
        .count      (txq_count)
    );

    always_comb begin
        next_r           = r;
        next_r.fifo_en_d = fifo_enable;
        next_r.overrun   = 1'b0;
        next_r.rdata     = RDATA_RESET;
        // (R5) queue head or buffer
        // (R12) upper bits read zero
        if (rd_hit) begin
            next_r.rdata = {UPPER_ZERO, fifo_enable ? rxq_data : r.rx_hold};
        end
        if (flush) begin
            next_r.rx_avail = 1'b0;
            next_r.tx_busy  = 1'b0;
        end else if (!fifo_enable) begin
            // (R4) read clears, arrival sets and wins
            if (rd_hit) begin
                next_r.rx_avail = 1'b0;
            end
            if (rx_valid) begin
                next_r.rx_hold  = rx_char;
                next_r.rx_avail = 1'b1;
                next_r.overrun  = r.rx_avail && !rd_hit;
            end
            // (R9) shifter takes holder, write sets and wins
            if (r.tx_busy && tx_char_ready) begin
                next_r.tx_busy = 1'b0;
            end
            if (wr_hit) begin
                next_r.tx_hold = reg_wdata[CHAR_W-1:0];
                next_r.tx_busy = 1'b1;
            end
        end else begin
            // (R6) full queue drops the arrival
            next_r.overrun = rx_valid && !rxq_push_ready;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // (R7) transmit target by link mode; ir pin inversion is in the shifter
    assign tx_valid               = fifo_enable ? txq_valid : r.tx_busy;
    assign tx_uart_valid          = tx_valid && (link_mode == USDP_UART);
    assign tx_ir_valid            = tx_valid && (link_mode == USDP_IR);
    assign tx_char                = fifo_enable ? txq_data : r.tx_hold;
    assign tx_holder_empty_flag   = fifo_enable ? !txq_valid : !r.tx_busy;
    assign rx_char_available_flag = fifo_enable ? rxq_valid : r.rx_avail;
    assign rx_overrun_pulse       = r.overrun;
    assign reg_rdata              = r.rdata;

    sequence s_plain_read;
        !fifo_enable && rd_hit;
    endsequence

    sequence s_plain_write;
        !fifo_enable && wr_hit && !flush;
    endsequence

    sequence s_queue_read;
        fifo_enable && rd_hit && rxq_valid && !flush;
    endsequence

    property p_alias_read;
        @(posedge clk_sys) disable iff (!rst_n)
        s_plain_read |=> reg_rdata[CHAR_W-1:0] == $past(r.rx_hold);
    endproperty
    a_alias_read: assert property (p_alias_read) // (R1)
        else $error("aliased read did not return receive buffer");

    property p_unmapped_read;
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && !port_hit |=> reg_rdata == RDATA_RESET;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) // (R1)
        else $error("unmapped read returned nonzero");

    property p_ir_receive;
        @(posedge clk_sys) disable iff (!rst_n)
        !fifo_enable && !flush && link_mode == USDP_IR && rx_ir_valid
            |=> r.rx_hold == $past(rx_ir_char) && rx_char_available_flag;
    endproperty
    a_ir_receive: assert property (p_ir_receive) // (R2)
        else $error("ir character not captured");

    property p_plain_overrun;
        @(posedge clk_sys) disable iff (!rst_n)
        !fifo_enable && !flush && rx_valid && r.rx_avail && !rd_hit
            |=> rx_overrun_pulse;
    endproperty
    a_plain_overrun: assert property (p_plain_overrun) // (R4)
        else $error("overwrite did not flag overrun");

    property p_queue_read;
        @(posedge clk_sys) disable iff (!rst_n)
        s_queue_read |=> reg_rdata[CHAR_W-1:0] == $past(rxq_data)
            && rxq_count == $past(rxq_count) - 1 + ($past(rx_valid) ? 1 : 0);
    endproperty
    a_queue_read: assert property (p_queue_read) // (R5)
        else $error("queue read did not return and advance head");

    property p_queue_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        fifo_enable && !flush && rx_valid && !rxq_push_ready
            |=> rx_overrun_pulse && rxq_count == QUEUE_DEPTH_DEFAULT;
    endproperty
    a_queue_drop: assert property (p_queue_drop) // (R6)
        else $error("full receive queue did not drop and flag");

    property p_tx_route;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_ir_valid |-> link_mode == USDP_IR && !tx_uart_valid;
    endproperty
    a_tx_route: assert property (p_tx_route) // (R7)
        else $error("ir transmit raised in uart mode");

    property p_single_write;
        @(posedge clk_sys) disable iff (!rst_n)
        s_plain_write ##0 (fifo_enable == $past(fifo_enable))
            |=> !tx_holder_empty_flag && tx_char == $past(reg_wdata[CHAR_W-1:0]);
    endproperty
    a_single_write: assert property (p_single_write) // (R9)
        else $error("write did not clear empty flag or replace char");

    property p_tx_bound;
        @(posedge clk_sys) disable iff (!rst_n)
        fifo_enable && !flush && wr_hit && !txq_push_ready
            |=> txq_count == TX_DEPTH;
    endproperty
    a_tx_bound: assert property (p_tx_bound) // (R10)
        else $error("write into full transmit queue not dropped");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rdata[31:CHAR_W] == UPPER_ZERO;
    endproperty
    a_reserved: assert property (p_reserved) // (R12)
        else $error("reserved read bits nonzero");

    property p_read_once;
        @(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == RDATA_RESET;
    endproperty
    a_read_once: assert property (p_read_once) // (R1)
        else $error("read data stood without a read");

    property p_uart_receive;
        @(posedge clk_sys) disable iff (!rst_n)
        !fifo_enable && !flush && link_mode == USDP_UART && rx_uart_valid
            |=> r.rx_hold == $past(rx_uart_char) && r.rx_avail;
    endproperty
    a_uart_receive: assert property (p_uart_receive) // (R2)
        else $error("uart character not captured");

    property p_plain_read_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        s_plain_read ##0 (!flush && !rx_valid) |=> !r.rx_avail;
    endproperty
    a_plain_read_clears: assert property (p_plain_read_clears) // (R4)
        else $error("read did not clear receive flag");

    property p_rx_accept;
        @(posedge clk_sys) disable iff (!rst_n)
        fifo_enable && !flush && rx_valid && !rd_hit
            && rxq_count < QUEUE_DEPTH_DEFAULT
            |=> rxq_count == $past(rxq_count) + 1 && !rx_overrun_pulse;
    endproperty
    a_rx_accept: assert property (p_rx_accept) // (R6)
        else $error("arrival with room not queued");

    property p_holder_taken;
        @(posedge clk_sys) disable iff (!rst_n)
        !fifo_enable && !flush && r.tx_busy && tx_char_ready && !wr_hit
            |=> !r.tx_busy;
    endproperty
    a_holder_taken: assert property (p_holder_taken) // (R9)
        else $error("taken holder still busy");

    property p_tx_accept;
        @(posedge clk_sys) disable iff (!rst_n)
        fifo_enable && !flush && wr_hit && !(txq_valid && tx_char_ready)
            && txq_count < TX_DEPTH
            |=> txq_count == $past(txq_count) + 1;
    endproperty
    a_tx_accept: assert property (p_tx_accept) // (R10)
        else $error("write with room not queued");

endmodule : usdp_port

// ### logic/usdp_queue.sv
/*
  Character queue: flip-flop storage addressed by read and write index.
  Assumes one clock; push and pop may happen in the same cycle, and a push
  into a full queue is accepted only when a pop frees a slot that cycle.
*/
`timescale 1ns/100ps
module usdp_queue #(
    parameter int DEPTH = usdp_pkg::QUEUE_DEPTH_DEFAULT
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic                           flush,
    input  wire logic                           push_valid,
    output logic                                push_ready,
    input  wire logic [usdp_pkg::CHAR_W-1:0]    push_data,
    output logic                                pop_valid,
    input  wire logic                           pop_ready,
    output logic [usdp_pkg::CHAR_W-1:0]         pop_data,
    output logic [$clog2(DEPTH+1)-1:0]          count
);
    import usdp_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] CW_ONE     = CW'(1);
    localparam logic [PW-1:0] PW_ONE     = PW'(1);

    typedef struct packed {
        logic [DEPTH-1:0][CHAR_W-1:0] mem;
        logic [PW-1:0]                rd;
        logic [PW-1:0]                wr;
        logic [CW-1:0]                cnt;
    } usdp_queue_s;

    usdp_queue_s r;
    usdp_queue_s next_r;
    logic        do_push;
    logic        do_pop;

    assign pop_valid  = (r.cnt != '0);
    assign pop_data   = r.mem[r.rd];
    assign do_pop     = pop_valid && pop_ready;
    assign push_ready = (r.cnt != FULL_COUNT) || do_pop;
    assign do_push    = push_valid && push_ready;
    assign count      = r.cnt;

    always_comb begin
        next_r = r;
        if (flush) begin
            next_r.rd  = '0;
            next_r.wr  = '0;
            next_r.cnt = '0;
        end else begin
            if (do_push) begin
                next_r.mem[r.wr] = push_data;
                next_r.wr        = r.wr + PW_ONE;
            end
            if (do_pop) begin
                next_r.rd = r.rd + PW_ONE;
            end
            if (do_push && !do_pop) begin
                next_r.cnt = r.cnt + CW_ONE;
            end else if (do_pop && !do_push) begin
                next_r.cnt = r.cnt - CW_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule : usdp_queue

// ### verification/tb.sv
/*
  Self-checking bench of the shadow character port: receive and transmit
  in both queue modes, aliases, unmapped places and overrun.
  Assumes usdp_pkg, usdp_port and usdp_far_end are compiled first.
*/
`timescale 1ns/100ps
module tb;
    import usdp_pkg::*;
    localparam int TXD = 4;
    logic            clk_sys     = 1'b0;
    logic            rst_n       = 1'b0;
    logic [31:0]     reg_addr    = 32'h0000_0000;
    logic [31:0]     reg_wdata   = 32'h0000_0000;
    logic            reg_wr      = 1'b0;
    logic            reg_rd      = 1'b0;
    logic            fifo_enable = 1'b0;
    usdp_link_e      link_mode   = USDP_UART;
    logic [31:0]     reg_rdata;
    logic            rx_uart_valid, rx_ir_valid, tx_uart_valid, tx_ir_valid;
    logic [7:0]      rx_uart_char, rx_ir_char, tx_char, ch;
    logic            tx_char_ready, rx_char_available_flag;
    logic            tx_holder_empty_flag, rx_overrun_pulse;
    logic [31:0]     d;
    logic [7:0]      exp_q[$];
    int              err_total    = 0;
    int              total_checks = 0;

    always #2 clk_sys = ~clk_sys;

    usdp_port #(.TX_DEPTH(TXD)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fifo_enable(fifo_enable), .link_mode(link_mode),
        .rx_uart_valid(rx_uart_valid), .rx_uart_char(rx_uart_char),
        .rx_ir_valid(rx_ir_valid), .rx_ir_char(rx_ir_char),
        .tx_uart_valid(tx_uart_valid), .tx_ir_valid(tx_ir_valid), .tx_char(tx_char),
        .tx_char_ready(tx_char_ready), .rx_char_available_flag(rx_char_available_flag),
        .tx_holder_empty_flag(tx_holder_empty_flag), .rx_overrun_pulse(rx_overrun_pulse));

    usdp_far_end sp (.clk_sys(clk_sys), .rst_n(rst_n),
        .rx_uart_valid(rx_uart_valid), .rx_uart_char(rx_uart_char),
        .rx_ir_valid(rx_ir_valid), .rx_ir_char(rx_ir_char),
        .tx_uart_valid(tx_uart_valid), .tx_ir_valid(tx_ir_valid), .tx_char(tx_char),
        .tx_char_ready(tx_char_ready));

    task automatic test_done();
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] exp_rd(input logic [7:0] c);
        return {UPPER_ZERO, c};
    endfunction : exp_rd

    function automatic logic [31:0] alias_addr();
        return CHAR_PORT_BASE + 32'(4 * ($urandom % CHAR_PORT_ALIASES));
    endfunction : alias_addr

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic wait_empty();
        int k;
        k = 0;
        while (tx_holder_empty_flag !== 1'b1 && k < 100) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
    endtask : wait_empty

    task automatic set_link(input usdp_link_e m);
        @(posedge clk_sys);
        link_mode <= m;
    endtask : set_link

    initial begin
        #20000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        void'($urandom(7));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk(reg_rdata, RDATA_RESET);
        chk(tx_holder_empty_flag, 1);
        chk(rx_char_available_flag, 0);
        for (int i = 0; i < 4; i++) begin
            set_link(usdp_link_e'(i[0]));
            ch = 8'($urandom);
            sp.send(usdp_link_e'(i[0]), ch);
            chk(rx_char_available_flag, 1);
            rd(alias_addr(), d);
            chk(d, exp_rd(ch));
            chk(rx_char_available_flag, 0);
        end
        sp.send(USDP_UART, 8'h5A);
        chk(rx_char_available_flag, 0);
        set_link(USDP_UART);
        sp.send(USDP_UART, 8'h11);
        chk(rx_overrun_pulse, 0);
        sp.send(USDP_UART, 8'hEE);
        chk(rx_overrun_pulse, 1);
        rd(CHAR_PORT_BASE + CHAR_PORT_SPAN, d);
        chk(d, 0);
        rd(CHAR_PORT_OWN + 32'h1, d);
        chk(d, 0);
        wr(CHAR_PORT_BASE + CHAR_PORT_SPAN, 32'h33);
        chk(tx_holder_empty_flag, 1);
        rd(CHAR_PORT_BASE + CHAR_PORT_SPAN - 32'h4, d);
        chk(d, exp_rd(8'hEE));
        wait_empty();
        wr(alias_addr(), {24'($urandom), 8'h41});
        chk(tx_holder_empty_flag, 0);
        chk(tx_char, 8'h41);
        chk(tx_uart_valid, 1);
        wr(alias_addr(), {24'($urandom), 8'h42});
        chk(tx_char, 8'h42);
        set_link(USDP_IR);
        #1;
        chk({tx_ir_valid, tx_uart_valid}, 2'b10);
        sp.go = 1'b1;
        wait_empty();
        sp.go = 1'b0;
        chk(tx_holder_empty_flag, 1);
        chk(sp.got_q.size(), 1);
        chk(sp.got_q[0], 8'h42);
        set_link(USDP_UART);
        fifo_enable <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i <= 16; i++) begin
            ch = 8'($urandom);
            if (i < 16) exp_q.push_back(ch);
            sp.send(USDP_UART, ch);
            chk(rx_overrun_pulse, 32'(i == 16));
        end
        for (int i = 0; i < 16; i++) begin
            rd(alias_addr(), d);
            chk(d, exp_rd(exp_q[i]));
        end
        chk(rx_char_available_flag, 0);
        exp_q.delete();
        sp.got_q.delete();
        wait_empty();
        for (int i = 0; i <= TXD; i++) begin
            ch = 8'($urandom);
            if (i < TXD) exp_q.push_back(ch);
            wr(alias_addr(), {24'h0, ch});
        end
        chk(tx_holder_empty_flag, 0);
        sp.fast = 1'b0;
        sp.go = 1'b1;
        wait_empty();
        chk(sp.got_q.size(), TXD);
        foreach (exp_q[i]) chk(sp.got_q[i], exp_q[i]);
        // mid-run reset with both queues holding a character
        sp.go = 1'b0;
        sp.send(USDP_UART, 8'h3C);
        wr(alias_addr(), 32'h0000_0077);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({rx_char_available_flag, tx_holder_empty_flag}, 2'b01);
        rd(alias_addr(), d);
        chk(d, exp_rd(CHAR_RESET));
        test_done();
    end
endmodule : tb

// ### verification/usdp_far_end.sv
/*
  Far side of the shadow character port: the uart and ir receivers that
  deliver characters, and the transmit shifter that takes them.
  Assumes clk_sys only; the bench calls send and sets go and fast.
*/
`timescale 1ns/100ps
module usdp_far_end (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    output logic                                rx_uart_valid,
    output logic [usdp_pkg::CHAR_W-1:0]         rx_uart_char,
    output logic                                rx_ir_valid,
    output logic [usdp_pkg::CHAR_W-1:0]         rx_ir_char,
    input  wire logic                           tx_uart_valid,
    input  wire logic                           tx_ir_valid,
    input  wire logic [usdp_pkg::CHAR_W-1:0]    tx_char,
    output logic                                tx_char_ready
);
    import usdp_pkg::*;
    logic            go   = 1'b0;
    logic            fast = 1'b1;
    logic [7:0]      got_q[$];

    initial begin
        rx_uart_valid = 1'b0;
        rx_ir_valid   = 1'b0;
        rx_uart_char  = 8'h00;
        rx_ir_char    = 8'hFF;
    end

    // one character per pulse, idle line shows inverse
    task automatic send(input usdp_link_e m, input logic [7:0] c);
        @(posedge clk_sys);
        rx_uart_valid <= (m == USDP_UART);
        rx_ir_valid   <= (m == USDP_IR);
        rx_uart_char  <= (m == USDP_UART) ? c : ~c;
        rx_ir_char    <= (m == USDP_IR) ? c : ~c;
        @(posedge clk_sys);
        rx_uart_valid <= 1'b0;
        rx_ir_valid   <= 1'b0;
        rx_uart_char  <= ~c;
        rx_ir_char    <= ~c;
        #1;
    endtask : send

    // shifter takes a character when offered and ready
    always @(posedge clk_sys) begin
        if (rst_n && (tx_uart_valid || tx_ir_valid) && tx_char_ready) begin
            got_q.push_back(tx_char);
        end
        tx_char_ready <= go && (fast || ($urandom_range(1) != 0));
    end
endmodule : usdp_far_end
